// *** branch_skip_load_exec.sv ***
// Summary of operation
// - Compares subtract constant or register plus carry; set Z,N,V,C,H; one cycle.
// - Register bit test skips next instruction on clear or set; 1/2/3 cycles.
// - I/O bit test skips on matching bit; PC advances two or three words.
// - Generic flag branch adds offset plus one when flag matches; 1/2 cycles.
// - Same-or-higher and carry-clear need C=0; lower and carry-set need C=1.
// - Signed GE taken when N xor V is 0; LT when it is 1.
// - Half-carry branches test H set or cleared; one or two cycles.
// - Transfer-bit branches test T set or cleared; one or two cycles.
// - Overflow branches test V set or cleared; one or two cycles.
// - Interrupt-state branches test I set or cleared; one or two cycles.
// - Indirect loads via X, Y, Z copy byte; post-increment bumps pointer; two cycles.
// - Pre-decrement loads lower the pointer first, then read; two cycles.
// - Displacement loads via Y or Z read pointer plus q; pointer unchanged.
// - Direct load reads byte at full address from second word; two cycles.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "branch_skip_load_regs.svh"
module branch_skip_load_exec (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   output logic      [15:0] mem_addr_o,
   output logic             mem_rd_o,
   input  wire logic [7:0]  mem_rdata_i,
   output logic      [4:0]  io_addr_o,
   output logic             io_rd_o,
   input  wire logic [7:0]  io_rdata_i,
   output logic             busy_o
);
   branch_skip_load_pkg::exec_state_type state_ff;
   branch_skip_load_pkg::exec_state_type nxt_state_ff;
   branch_skip_load_pkg::pend_type       pend_ff;
   branch_skip_load_pkg::pend_type       nxt_pend_ff;

   logic [7:0]  regs_ff     [32];
   logic [7:0]  nxt_regs_ff [32];
   logic [15:0] pc_ff;
   logic [15:0] nxt_pc_ff;
   logic [7:0]  flags_ff;
   logic [7:0]  nxt_flags_ff;
   logic [15:0] operand_ff;
   logic [15:0] nxt_operand_ff;
   logic [15:0] next_ff;
   logic [15:0] nxt_next_ff;
   logic [4:0]  idx_ff;
   logic [4:0]  nxt_idx_ff;
   logic [4:0]  dest_ff;
   logic [4:0]  nxt_dest_ff;
   logic [2:0]  bit_ff;
   logic [2:0]  nxt_bit_ff;
   logic [1:0]  hold_ff;
   logic [1:0]  nxt_hold_ff;
   logic [1:0]  cycles_ff;
   logic [1:0]  nxt_cycles_ff;
   logic        illegal_ff;
   logic        nxt_illegal_ff;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata_ff;
   logic [15:0] mem_addr_ff;
   logic [15:0] nxt_mem_addr_ff;
   logic        mem_rd_ff;
   logic        nxt_mem_rd_ff;
   logic [4:0]  io_addr_ff;
   logic [4:0]  nxt_io_addr_ff;
   logic        io_rd_ff;
   logic        nxt_io_rd_ff;
   logic        busy_ff;
   logic        nxt_busy_ff;

   logic [15:0] instr;
   logic        launch;
   logic [4:0]  d_full;
   logic [4:0]  r_full;
   logic [4:0]  d_high;
   logic [7:0]  imm;
   logic [15:0] br_target;
   logic        next_long;
   logic [15:0] skip_step;
   logic [1:0]  skip_cycles;
   logic        br_taken;
   logic [4:0]  ptr_lo;
   logic [15:0] ptr_val;
   logic [15:0] ptr_dec;
   logic [15:0] ptr_inc;
   logic [5:0]  disp;
   logic        is_cpc;
   logic        is_cpi;
   logic        is_ldind;
   logic        ind_post;
   logic        ind_pre;
   logic        ind_ok;

   cmp_if cmp ();

   assign instr       = wdata_i;
   assign launch      = wr_i && (addr_i == `OFF_INSTR) && (state_ff == branch_skip_load_pkg::ST_IDLE);
   assign d_full      = instr[8:4];
   assign r_full      = {instr[9], instr[3:0]};
   assign d_high      = {1'b1, instr[7:4]};
   assign imm         = {instr[11:8], instr[3:0]};
   assign br_target   = pc_ff + {{9{instr[9]}}, instr[9:3]} + 16'h0001;
   assign next_long   = ((next_ff & `MSK_LONG_A) == `PAT_LONG_A) || ((next_ff & `MSK_LONG_B) == `PAT_LONG_B);
   assign skip_step   = next_long ? 16'h0003 : 16'h0002;
   assign skip_cycles = next_long ? `CYC_THREE : `CYC_TWO;
   assign is_cpc      = (instr & `MSK_CPC) == `PAT_CPC;
   assign is_cpi      = (instr & `MSK_CPI) == `PAT_CPI;
   assign is_ldind    = (instr & `MSK_LDIND) == `PAT_LDIND;
   assign ind_post    = (instr[3:0] == 4'h1) || (instr[3:0] == 4'h9) || (instr[3:0] == 4'hd);
   assign ind_pre     = (instr[3:0] == 4'h2) || (instr[3:0] == 4'ha) || (instr[3:0] == 4'he);
   assign ind_ok      = is_ldind && (ind_post || ind_pre || (instr[3:0] == 4'hc));
   assign disp        = {instr[13], instr[11:10], instr[2:0]};

   // Pointer pair selection shared by indirect and displacement loads
   always_comb begin
      if (is_ldind) begin
         if (instr[3:2] == 2'h3) begin
            ptr_lo = `PTR_X;
         end else if (instr[3]) begin
            ptr_lo = `PTR_Y;
         end else begin
            ptr_lo = `PTR_Z;
         end
      end else begin
         ptr_lo = instr[3] ? `PTR_Y : `PTR_Z;
      end
      ptr_val = {regs_ff[ptr_lo + 5'h01], regs_ff[ptr_lo]};
      ptr_dec = ptr_val - 16'h0001;
      ptr_inc = ptr_val + 16'h0001;
   end

   assign cmp.lhs       = regs_ff[is_cpi ? d_high : d_full];
   assign cmp.rhs       = is_cpi ? imm : regs_ff[r_full];
   assign cmp.use_carry = is_cpc;
   assign cmp.flags_in  = flags_ff;

   compare_unit u_compare (
      .cmp (cmp.unit)
   );

   flag_cond u_flag_cond (
      .flags_i    (flags_ff),
      .sel_i      (instr[2:0]),
      .want_set_i (~instr[10]),
      .taken_o    (br_taken)
   );

   always_comb begin
      nxt_state_ff    = state_ff;
      nxt_pend_ff     = pend_ff;
      nxt_regs_ff     = regs_ff;
      nxt_pc_ff       = pc_ff;
      nxt_flags_ff    = flags_ff;
      nxt_operand_ff  = operand_ff;
      nxt_next_ff     = next_ff;
      nxt_idx_ff      = idx_ff;
      nxt_dest_ff     = dest_ff;
      nxt_bit_ff      = bit_ff;
      nxt_hold_ff     = hold_ff;
      nxt_cycles_ff   = cycles_ff;
      nxt_illegal_ff  = illegal_ff;
      nxt_rdata_ff    = 16'h0000;
      nxt_mem_addr_ff = mem_addr_ff;
      nxt_mem_rd_ff   = 1'b0;
      nxt_io_addr_ff  = io_addr_ff;
      nxt_io_rd_ff    = 1'b0;

      if (rd_i) begin
         case (addr_i)
            `OFF_OPERAND:  nxt_rdata_ff = operand_ff;
            `OFF_NEXT:     nxt_rdata_ff = next_ff;
            `OFF_PC:       nxt_rdata_ff = pc_ff;
            `OFF_FLAGS:    nxt_rdata_ff = {8'h00, flags_ff};
            `OFF_CTRL:     nxt_rdata_ff = {12'h000, cycles_ff, illegal_ff, busy_ff};
            `OFF_REG_IDX:  nxt_rdata_ff = {11'h000, idx_ff};
            `OFF_REG_DATA: nxt_rdata_ff = {8'h00, regs_ff[idx_ff]};
            default:       nxt_rdata_ff = 16'h0000;
         endcase
      end

      // Architectural state is frozen to software while an instruction runs
      if (wr_i && (state_ff == branch_skip_load_pkg::ST_IDLE)) begin
         case (addr_i)
            `OFF_OPERAND:  nxt_operand_ff = wdata_i;
            `OFF_NEXT:     nxt_next_ff = wdata_i;
            `OFF_PC:       nxt_pc_ff = wdata_i;
            `OFF_FLAGS:    nxt_flags_ff = wdata_i[7:0];
            `OFF_REG_IDX:  nxt_idx_ff = wdata_i[4:0];
            `OFF_REG_DATA: nxt_regs_ff[idx_ff] = wdata_i[7:0];
            default:       nxt_idx_ff = idx_ff;
         endcase
      end

      if (launch) begin
         nxt_illegal_ff = 1'b0;
         nxt_cycles_ff  = `CYC_ONE;
         nxt_pc_ff      = pc_ff + 16'h0001;
         if (is_cpc || is_cpi) begin
            nxt_flags_ff = cmp.flags_out;
         end else if ((instr & `MSK_MOV) == `PAT_MOV) begin
            nxt_regs_ff[d_full] = regs_ff[r_full];
         end else if ((instr & `MSK_PAIR_COPY) == `PAT_PAIR_COPY) begin
            nxt_regs_ff[{instr[7:4], 1'b0}] = regs_ff[{instr[3:0], 1'b0}];
            nxt_regs_ff[{instr[7:4], 1'b1}] = regs_ff[{instr[3:0], 1'b1}];
         end else if ((instr & `MSK_LDI) == `PAT_LDI) begin
            nxt_regs_ff[d_high] = imm;
         end else if ((instr & `MSK_SBR) == `PAT_SBR) begin
            if (regs_ff[d_full][instr[2:0]] == instr[9]) begin
               nxt_pc_ff     = pc_ff + skip_step;
               nxt_cycles_ff = skip_cycles;
               nxt_hold_ff   = skip_cycles - `CYC_ONE;
               nxt_state_ff  = branch_skip_load_pkg::ST_HOLD;
            end
         end else if ((instr & `MSK_SBI) == `PAT_SBI) begin
            nxt_pc_ff      = pc_ff;
            nxt_io_addr_ff = instr[7:3];
            nxt_io_rd_ff   = 1'b1;
            nxt_bit_ff     = instr[2:0];
            nxt_pend_ff    = instr[9] ? branch_skip_load_pkg::PEND_IO_SET : branch_skip_load_pkg::PEND_IO_CLR;
            nxt_state_ff   = branch_skip_load_pkg::ST_MEM_WAIT;
         end else if ((instr & `MSK_BRB) == `PAT_BRB) begin
            // Named branches are fixed flag indices of this form
            if (br_taken) begin
               nxt_pc_ff     = br_target;
               nxt_cycles_ff = `CYC_TWO;
               nxt_hold_ff   = `CYC_ONE;
               nxt_state_ff  = branch_skip_load_pkg::ST_HOLD;
            end
         end else if ((instr & `MSK_LDS) == `PAT_LDS) begin
            nxt_pc_ff       = pc_ff + 16'h0002;
            nxt_mem_addr_ff = operand_ff;
            nxt_mem_rd_ff   = 1'b1;
            nxt_dest_ff     = d_full;
            nxt_cycles_ff   = `CYC_TWO;
            nxt_pend_ff     = branch_skip_load_pkg::PEND_LOAD;
            nxt_state_ff    = branch_skip_load_pkg::ST_MEM_WAIT;
         end else if (ind_ok) begin
            nxt_mem_addr_ff = ind_pre ? ptr_dec : ptr_val;
            if (ind_pre || ind_post) begin
               nxt_regs_ff[ptr_lo]         = ind_pre ? ptr_dec[7:0] : ptr_inc[7:0];
               nxt_regs_ff[ptr_lo + 5'h01] = ind_pre ? ptr_dec[15:8] : ptr_inc[15:8];
            end
            nxt_mem_rd_ff = 1'b1;
            nxt_dest_ff   = d_full;
            nxt_cycles_ff = `CYC_TWO;
            nxt_pend_ff   = branch_skip_load_pkg::PEND_LOAD;
            nxt_state_ff  = branch_skip_load_pkg::ST_MEM_WAIT;
         end else if ((instr & `MSK_LDD) == `PAT_LDD) begin
            nxt_mem_addr_ff = ptr_val + {10'h000, disp};
            nxt_mem_rd_ff   = 1'b1;
            nxt_dest_ff     = d_full;
            nxt_cycles_ff   = `CYC_TWO;
            nxt_pend_ff     = branch_skip_load_pkg::PEND_LOAD;
            nxt_state_ff    = branch_skip_load_pkg::ST_MEM_WAIT;
         end else begin
            // Outside this unit: the program counter is left alone
            nxt_pc_ff      = pc_ff;
            nxt_cycles_ff  = 2'h0;
            nxt_illegal_ff = 1'b1;
         end
      end

      case (state_ff)
         branch_skip_load_pkg::ST_IDLE: begin
            nxt_hold_ff = launch ? nxt_hold_ff : 2'h0;
         end
         branch_skip_load_pkg::ST_MEM_WAIT: begin
            nxt_state_ff = branch_skip_load_pkg::ST_MEM_CAP;
         end
         branch_skip_load_pkg::ST_MEM_CAP: begin
            nxt_state_ff = branch_skip_load_pkg::ST_IDLE;
            if (pend_ff == branch_skip_load_pkg::PEND_LOAD) begin
               nxt_regs_ff[dest_ff] = mem_rdata_i;
            end else if (io_rdata_i[bit_ff] == (pend_ff == branch_skip_load_pkg::PEND_IO_SET)) begin
               nxt_pc_ff     = pc_ff + skip_step;
               nxt_cycles_ff = skip_cycles;
            end else begin
               nxt_pc_ff     = pc_ff + 16'h0001;
               nxt_cycles_ff = `CYC_ONE;
            end
         end
         branch_skip_load_pkg::ST_HOLD: begin
            nxt_hold_ff = hold_ff - 2'h1;
            if (hold_ff <= 2'h1) begin
               nxt_state_ff = branch_skip_load_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state_ff = branch_skip_load_pkg::ST_IDLE;
         end
      endcase

      nxt_busy_ff = (nxt_state_ff != branch_skip_load_pkg::ST_IDLE);
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_ff    <= branch_skip_load_pkg::ST_IDLE;
         pend_ff     <= branch_skip_load_pkg::PEND_LOAD;
         regs_ff     <= '{default: 8'h00};
         pc_ff       <= `PC_RESET;
         flags_ff    <= `FLAGS_RESET;
         operand_ff  <= `WORD_RESET;
         next_ff     <= `WORD_RESET;
         idx_ff      <= 5'h00;
         dest_ff     <= 5'h00;
         bit_ff      <= 3'h0;
         hold_ff     <= 2'h0;
         cycles_ff   <= 2'h0;
         illegal_ff  <= 1'b0;
         rdata_ff    <= 16'h0000;
         mem_addr_ff <= 16'h0000;
         mem_rd_ff   <= 1'b0;
         io_addr_ff  <= 5'h00;
         io_rd_ff    <= 1'b0;
         busy_ff     <= 1'b0;
      end else begin
         state_ff    <= nxt_state_ff;
         pend_ff     <= nxt_pend_ff;
         regs_ff     <= nxt_regs_ff;
         pc_ff       <= nxt_pc_ff;
         flags_ff    <= nxt_flags_ff;
         operand_ff  <= nxt_operand_ff;
         next_ff     <= nxt_next_ff;
         idx_ff      <= nxt_idx_ff;
         dest_ff     <= nxt_dest_ff;
         bit_ff      <= nxt_bit_ff;
         hold_ff     <= nxt_hold_ff;
         cycles_ff   <= nxt_cycles_ff;
         illegal_ff  <= nxt_illegal_ff;
         rdata_ff    <= nxt_rdata_ff;
         mem_addr_ff <= nxt_mem_addr_ff;
         mem_rd_ff   <= nxt_mem_rd_ff;
         io_addr_ff  <= nxt_io_addr_ff;
         io_rd_ff    <= nxt_io_rd_ff;
         busy_ff     <= nxt_busy_ff;
      end
   end

   assign rdata_o    = rdata_ff;
   assign mem_addr_o = mem_addr_ff;
   assign mem_rd_o   = mem_rd_ff;
   assign io_addr_o  = io_addr_ff;
   assign io_rd_o    = io_rd_ff;
   assign busy_o     = busy_ff;
endmodule

// *** branch_skip_load_regs.svh ***
`ifndef BRANCH_SKIP_LOAD_REGS_SVH
`define BRANCH_SKIP_LOAD_REGS_SVH

// Register port offsets
`define OFF_INSTR     8'h00
`define OFF_OPERAND   8'h01
`define OFF_NEXT      8'h02
`define OFF_PC        8'h03
`define OFF_FLAGS     8'h04
`define OFF_CTRL      8'h05
`define OFF_REG_IDX   8'h06
`define OFF_REG_DATA  8'h07

// Reset values
`define PC_RESET      16'h0000
`define FLAGS_RESET   8'h00
`define WORD_RESET    16'h0000

// Status flag positions
`define FLAG_C        3'h0
`define FLAG_Z        3'h1
`define FLAG_N        3'h2
`define FLAG_V        3'h3
`define FLAG_S        3'h4
`define FLAG_H        3'h5
`define FLAG_T        3'h6
`define FLAG_I        3'h7

// Control/status register bit positions
`define CTRL_BUSY     0
`define CTRL_ILLEGAL  1
`define CTRL_CYC_LO   2
`define CTRL_CYC_HI   3

// Opcode masks and patterns
`define MSK_CPC       16'hfc00
`define PAT_CPC       16'h0400
`define MSK_CPI       16'hf000
`define PAT_CPI       16'h3000
`define MSK_MOV       16'hfc00
`define PAT_MOV       16'h2c00
`define MSK_PAIR_COPY      16'hff00
`define PAT_PAIR_COPY      16'h0100
`define MSK_LDI       16'hf000
`define PAT_LDI       16'he000
`define MSK_SBR       16'hfc08
`define PAT_SBR       16'hfc00
`define MSK_SBI       16'hfd00
`define PAT_SBI       16'h9900
`define MSK_BRB       16'hf800
`define PAT_BRB       16'hf000
`define MSK_LDS       16'hfe0f
`define PAT_LDS       16'h9000
`define MSK_LDIND     16'hfe00
`define PAT_LDIND     16'h9000
`define MSK_LDD       16'hd200
`define PAT_LDD       16'h8000
`define MSK_LONG_A    16'hfc0f
`define PAT_LONG_A    16'h9000
`define MSK_LONG_B    16'hfe0c
`define PAT_LONG_B    16'h940c

// Pointer pair low register indices
`define PTR_X         5'h1a
`define PTR_Y         5'h1c
`define PTR_Z         5'h1e

// Cycle counts
`define CYC_ONE       2'h1
`define CYC_TWO       2'h2
`define CYC_THREE     2'h3

`endif

// *** branch_skip_load_pkg.sv ***
package branch_skip_load_pkg;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0001,
      ST_MEM_WAIT = 4'b0010,
      ST_MEM_CAP  = 4'b0100,
      ST_HOLD     = 4'b1000
   } exec_state_type;

   typedef enum logic [1:0] {
      PEND_LOAD   = 2'h0,
      PEND_IO_CLR = 2'h1,
      PEND_IO_SET = 2'h2
   } pend_type;

endpackage

// *** cmp_if.sv ***
`timescale 1ns/1ps
interface cmp_if;
   logic [7:0] lhs;
   logic [7:0] rhs;
   logic       use_carry;
   logic [7:0] flags_in;
   logic [7:0] flags_out;

   modport unit (input lhs, rhs, use_carry, flags_in, output flags_out);
   modport user (output lhs, rhs, use_carry, flags_in, input flags_out);
endinterface

// *** compare_unit.sv ***
`timescale 1ns/1ps
`include "branch_skip_load_regs.svh"
module compare_unit (
   cmp_if.unit cmp
);
   logic [7:0] diff;
   logic       cin;
   logic       n_bit;
   logic       v_bit;

   always_comb begin
      cin   = cmp.use_carry & cmp.flags_in[`FLAG_C];
      diff  = cmp.lhs - cmp.rhs - {7'h00, cin};
      n_bit = diff[7];
      v_bit = (cmp.lhs[7] & ~cmp.rhs[7] & ~diff[7]) | (~cmp.lhs[7] & cmp.rhs[7] & diff[7]);
      cmp.flags_out = cmp.flags_in;
      cmp.flags_out[`FLAG_H] = (~cmp.lhs[3] & cmp.rhs[3]) | (cmp.rhs[3] & diff[3]) | (diff[3] & ~cmp.lhs[3]);
      cmp.flags_out[`FLAG_C] = (~cmp.lhs[7] & cmp.rhs[7]) | (cmp.rhs[7] & diff[7]) | (diff[7] & ~cmp.lhs[7]);
      cmp.flags_out[`FLAG_N] = n_bit;
      cmp.flags_out[`FLAG_V] = v_bit;
      cmp.flags_out[`FLAG_S] = n_bit ^ v_bit;
      // With carry the zero flag can only be cleared or kept, never set, so multi-byte compares chain
      cmp.flags_out[`FLAG_Z] = (diff == 8'h00) & (~cmp.use_carry | cmp.flags_in[`FLAG_Z]);
   end
endmodule

// *** flag_cond.sv ***
`timescale 1ns/1ps
`include "branch_skip_load_regs.svh"
module flag_cond (
   input  wire logic [7:0] flags_i,
   input  wire logic [2:0] sel_i,
   input  wire logic       want_set_i,
   output logic            taken_o
);
   logic picked;

   always_comb begin
      // Signed test is formed from negative and overflow, not the stored bit
      if (sel_i == `FLAG_S) begin
         picked = flags_i[`FLAG_N] ^ flags_i[`FLAG_V];
      end else begin
         picked = flags_i[sel_i];
      end
      taken_o = (picked == want_set_i);
   end
endmodule

// *** branch_skip_load_chk.sv ***
`timescale 1ns/1ps
`include "branch_skip_load_regs.svh"
module branch_skip_load_chk (
   input wire logic        ref_clk_i,
   input wire logic        reset_i,
   input wire logic [7:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic        mem_rd_o,
   input wire logic [7:0]  mem_rdata_i,
   input wire logic [4:0]  io_addr_o,
   input wire logic        io_rd_o,
   input wire logic [7:0]  io_rdata_i,
   input wire logic        busy_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   logic iw;
   // Instruction write that the block accepts
   assign iw = wr_i && (addr_i == `OFF_INSTR) && !busy_o;
   a_load_launch: assert property (mem_rd_o |-> $past(iw) && busy_o)
      else $error("load request without instruction");
   a_load_span: assert property (mem_rd_o |=> busy_o ##1 !busy_o)
      else $error("load busy span wrong");
   a_load_pulse: assert property (mem_rd_o |=> !mem_rd_o)
      else $error("load request longer than one cycle");
   a_io_launch: assert property (io_rd_o |-> $past(iw) && busy_o)
      else $error("io request without instruction");
   a_io_span: assert property (io_rd_o |=> (busy_o && !io_rd_o) ##1 !busy_o)
      else $error("io busy span wrong");
   a_busy_bound: assert property ($rose(busy_o) |-> ##[1:2] !busy_o)
      else $error("busy too long");
   a_busy_cause: assert property ($rose(busy_o) |-> $past(iw))
      else $error("busy without instruction");
   a_read_slot: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside its slot");
   a_addr_hold: assert property (!mem_rd_o |-> $stable(mem_addr_o))
      else $error("data address moved without request");
   c_load: cover property (mem_rd_o);
   c_io: cover property (io_rd_o);
   c_taken: cover property ($rose(busy_o) && !mem_rd_o && !io_rd_o);
endmodule

bind branch_skip_load_exec branch_skip_load_chk u_chk (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i),
   .io_addr_o(io_addr_o), .io_rd_o(io_rd_o), .io_rdata_i(io_rdata_i), .busy_o(busy_o)
);

// *** data_space_model.sv ***
`timescale 1ns/1ps
module data_space_model (
   input  wire logic [0:0]  ref_clk_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic        mem_rd_i,
   output logic      [7:0]  mem_rdata_o,
   input  wire logic [4:0]  io_addr_i,
   input  wire logic        io_rd_i,
   output logic      [7:0]  io_rdata_o
);
   initial begin
      mem_rdata_o = 8'h00;
      io_rdata_o = 8'h00;
   end
   // Data valid only in the slot after a request, scrambled otherwise
   always @(posedge ref_clk_i) begin
      mem_rdata_o <= mem_rd_i ? (mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h5a) : ~mem_rdata_o;
      io_rdata_o <= io_rd_i ? ({3'h0, io_addr_i} ^ 8'h3c) : ~io_rdata_o;
   end
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "branch_skip_load_regs.svh"
module tb;
   logic        ref_clk_i;
   logic        reset_i;
   logic [7:0]  addr_i;
   logic [15:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [15:0] rdata_o;
   logic [15:0] mem_addr_o;
   logic        mem_rd_o;
   logic [7:0]  mem_rdata_i;
   logic [4:0]  io_addr_o;
   logic        io_rd_o;
   logic [7:0]  io_rdata_i;
   logic        busy_o;
   int          failures;
   int          tests_run;

   branch_skip_load_exec u_dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
      .mem_rdata_i(mem_rdata_i), .io_addr_o(io_addr_o), .io_rd_o(io_rd_o), .io_rdata_i(io_rdata_i),
      .busy_o(busy_o));
   data_space_model u_mem (.ref_clk_i(ref_clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
      .mem_rdata_o(mem_rdata_i), .io_addr_i(io_addr_o), .io_rd_i(io_rd_o), .io_rdata_o(io_rdata_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic end_of_test();
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic ck(input logic [7:0] a, input string n, input logic [15:0] e);
      logic [15:0] v;
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
      chk(n, e, v);
      @(posedge ref_clk_i);
   endtask

   task automatic setr(input logic [4:0] i, input logic [7:0] v);
      wr(`OFF_REG_IDX, {11'h000, i});
      wr(`OFF_REG_DATA, {8'h00, v});
   endtask

   task automatic ckr(input logic [4:0] i, input logic [7:0] e);
      wr(`OFF_REG_IDX, {11'h000, i});
      ck(`OFF_REG_DATA, $sformatf("r%0d", i), {8'h00, e});
   endtask

   task automatic ex(input logic [15:0] ins);
      int n;
      n = 0;
      wr(`OFF_INSTR, ins);
      #1;
      while (busy_o !== 1'b0 && n < 8) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      chk("busy", 16'h0000, {15'h0000, busy_o});
      @(posedge ref_clk_i);
   endtask

   task automatic sk(input logic [15:0] ins, input logic [15:0] nx, input logic [1:0] c);
      wr(`OFF_PC, 16'h0100);
      wr(`OFF_NEXT, nx);
      ex(ins);
      ck(`OFF_PC, "skip_pc", 16'h0100 + {14'h0000, c});
      ck(`OFF_CTRL, "skip_cycles", {12'h000, c, 2'b00});
   endtask

   task automatic t_reset();
      ck(`OFF_PC, "pc_reset", 16'h0000);
      ck(`OFF_FLAGS, "flags_reset", 16'h0000);
      ck(`OFF_CTRL, "ctrl_reset", 16'h0000);
      wr(8'h41, 16'hffff);
      ck(8'h40, "unmapped", 16'h0000);
      ckr(5'd5, 8'h00);
   endtask

   task automatic t_branches();
      logic [7:0] pats [3] = '{8'h00, 8'hff, 8'h04};
      logic       tk;
      for (int p = 0; p < 3; p++) begin
         for (int s = 0; s < 8; s++) begin
            for (int w = 0; w < 2; w++) begin
               tk = ((s == 4) ? (pats[p][2] ^ pats[p][3]) : pats[p][s]) == w[0];
               wr(`OFF_FLAGS, {8'h00, pats[p]});
               wr(`OFF_PC, 16'h0040);
               ex({5'b11110, !w[0], 7'h7d, s[2:0]});
               ck(`OFF_PC, "branch_pc", tk ? 16'h003e : 16'h0041);
               ck(`OFF_FLAGS, "branch_flags", {8'h00, pats[p]});
               ck(`OFF_CTRL, "branch_cycles", tk ? 16'h0008 : 16'h0004);
            end
         end
      end
   endtask

   task automatic t_compare();
      logic [15:0] ins [6] = '{16'h3200, 16'h3100, 16'h3031, 16'h0712, 16'h0712, 16'h0712};
      logic [7:0]  fin [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
      logic [7:0]  fex [6] = '{8'h05, 8'h02, 8'h28, 8'h25, 8'h02, 8'h00};
      logic [15:0] v;
      setr(5'd16, 8'h10);
      setr(5'd17, 8'h05);
      setr(5'd18, 8'h05);
      setr(5'd19, 8'h80);
      for (int i = 0; i < 6; i++) begin
         wr(`OFF_FLAGS, {8'h00, fin[i]});
         wr(`OFF_PC, 16'h0000);
         ex(ins[i]);
         addr_i <= `OFF_FLAGS;
         rd_i <= 1'b1;
         @(posedge ref_clk_i);
         rd_i <= 1'b0;
         #1 v = rdata_o;
         chk("cmp_flags", {8'h00, fex[i]}, v & 16'h002f);
         @(posedge ref_clk_i);
         ck(`OFF_PC, "cmp_pc", 16'h0001);
      end
      ckr(5'd16, 8'h10);
      ckr(5'd17, 8'h05);
   endtask

   task automatic t_moves();
      wr(`OFF_FLAGS, 16'h005a);
      wr(`OFF_PC, 16'h0000);
      ex(16'hea45);
      ex(16'he35c);
      ex(16'h2e34);
      ex(16'h012a);
      ckr(5'd20, 8'ha5);
      ckr(5'd21, 8'h3c);
      ckr(5'd3, 8'ha5);
      ckr(5'd4, 8'ha5);
      ckr(5'd5, 8'h3c);
      ck(`OFF_FLAGS, "move_flags", 16'h005a);
      ck(`OFF_PC, "move_pc", 16'h0004);
      ck(`OFF_CTRL, "move_cycles", 16'h0004);
   endtask

   task automatic t_skips();
      sk(16'hfc41, 16'h0000, 2'd2);
      sk(16'hfc41, 16'h9000, 2'd3);
      sk(16'hfc40, 16'h0000, 2'd1);
      sk(16'hfe40, 16'h0000, 2'd2);
      sk(16'hfe46, 16'h9000, 2'd1);
      sk(16'h9b28, 16'h0000, 2'd2);
      sk(16'h9929, 16'h9000, 2'd3);
      sk(16'h9b29, 16'h0000, 2'd1);
      sk(16'h99ff, 16'h0000, 2'd2);
      chk("io_addr", 16'h001f, {11'h000, io_addr_o});
   endtask

   task automatic t_loads();
      logic [7:0]  pv [6] = '{8'h20, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03};
      logic [7:0]  pe [6] = '{8'h21, 8'h01, 8'hff, 8'h01, 8'h01, 8'h03};
      logic [15:0] ins [6] = '{16'h901d, 16'h902a, 16'hac67, 16'h9091, 16'h907c, 16'h9080};
      logic [4:0]  dst [6] = '{5'd1, 5'd2, 5'd6, 5'd9, 5'd7, 5'd8};
      logic [7:0]  ex_v [6] = '{8'h7b, 8'ha4, 8'h66, 8'h59, 8'h7a, 8'h08};
      for (int i = 0; i < 6; i++) begin
         setr(5'(26 + i), pv[i]);
      end
      wr(`OFF_FLAGS, 16'h00c3);
      wr(`OFF_PC, 16'h0000);
      wr(`OFF_OPERAND, 16'h0456);
      for (int i = 0; i < 6; i++) begin
         ex(ins[i]);
         ckr(dst[i], ex_v[i]);
         ck(`OFF_CTRL, "load_cycles", 16'h0008);
      end
      for (int i = 0; i < 6; i++) begin
         ckr(5'(26 + i), pe[i]);
      end
      ck(`OFF_PC, "load_pc", 16'h0007);
      ck(`OFF_FLAGS, "load_flags", 16'h00c3);
   endtask

   task automatic t_refused();
      wr(`OFF_PC, 16'h0010);
      wr(`OFF_INSTR, 16'h901c);
      wr(`OFF_PC, 16'h0077);
      ck(`OFF_PC, "busy_write", 16'h0011);
      ckr(5'd1, 8'h7a);
   endtask

   initial begin
      reset_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 16'h0000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      failures = 0;
      tests_run = 0;
      repeat (8) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      @(posedge ref_clk_i);
      t_reset();
      t_branches();
      t_compare();
      t_moves();
      t_skips();
      t_loads();
      t_refused();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      failures++;
      end_of_test();
   end
endmodule
